// ### verilog/payload_mapper.v
`timescale 1ns/10ps
`include "payload_mapper_regs.vh"

// ************************************************************
// Payload mapper: user stream into payload sub-block bit slots.
// ************************************************************
module payload_mapper
(
   mclk,
   rstn,
   byte_mode,
   payload_bits,
   slot_count,
   sb_start,
   bit_req,
   user_bit,
   user_bit_valid,
   user_bit_ready,
   user_byte,
   user_byte_valid,
   user_byte_ready,
   tx_bit,
   tx_bit_valid,
   config_error
);
   input  wire                   mclk;
   input  wire                   rstn;
   input  wire                   byte_mode;
   input  wire [`BITS_W-1:0]     payload_bits;
   input  wire [`SLOTS_W-1:0]    slot_count;
   input  wire                   sb_start;
   input  wire                   bit_req;
   input  wire                   user_bit;
   input  wire                   user_bit_valid;
   output wire                   user_bit_ready;
   input  wire [7:0]             user_byte;
   input  wire                   user_byte_valid;
   output wire                   user_byte_ready;
   output reg                    tx_bit;
   output reg                    tx_bit_valid;
   output reg                    config_error;

   reg  [`BITS_W-1:0] bit_cnt_reg;
   reg  [`BITS_W-1:0] bit_cnt_next;
   reg  [2:0]         phase_reg;
   reg  [2:0]         phase_next;
   reg  [1:0]         state_reg;
   reg  [1:0]         state_next;
   wire [`BITS_W-1:0] block_len;
   wire [`BITS_W-1:0] last_pos;
   wire               cfg_ok;
   wire               in_block;
   wire               slots_ok;
   wire               take;
   wire               last_take;
   wire               slot_first;
   wire               byte_load;
   wire               byte_shift;
   wire               bit_take;
   wire [7:0]         byte_rest;
   wire               lsb;

   // Sub-block fill states.
   localparam ST_OPEN = 2'b00;
   localparam ST_FULL = 2'b01;
   localparam ST_BAD  = 2'b10;

   // ************************************************************
   // Configuration.
   // ************************************************************
   // eight bits per slot.
   assign block_len = byte_mode ? {slot_count, 3'b000} : payload_bits;
   assign slots_ok  = (slot_count >= `SLOTS_MIN) && (slot_count < `SLOTS_MAX_EXCL);
   assign cfg_ok    = !byte_mode || slots_ok;
   // The last position is only used while the block is open, so the wrap of an
   // empty block length is never seen.
   assign last_pos  = block_len - `BIT_STEP;
   assign in_block  = (state_reg == ST_OPEN) && (bit_cnt_reg < block_len) && cfg_ok;

   // ************************************************************
   // Request acceptance.
   // ************************************************************
   // A request in the sub-block start cycle is dropped, so no data is handed
   // over then and the user stream does not lose a bit.
   // start cycle wins.
   assign take            = bit_req && !sb_start && in_block;
   assign last_take       = take && (bit_cnt_reg == last_pos);
   assign slot_first      = (phase_reg == `PHASE_RESET);
   assign byte_load       = byte_mode && take && slot_first;
   assign byte_shift      = byte_mode && take && !slot_first;
   assign user_byte_ready = byte_load;
   // bits one to seven held back.
   assign byte_rest       = user_byte_valid ? {1'h0, user_byte[7:1]} : `FILL_REST;
   assign bit_take        = !byte_mode && take;
   assign user_bit_ready  = bit_take;

   bit_shift_reg u_shift
   (
      .mclk      (mclk),
      .rstn      (rstn),
      .load      (byte_load),
      .load_data (byte_rest),
      .shift     (byte_shift),
      .lsb       (lsb)
   );

   // ************************************************************
   // Bit position counter.
   // ************************************************************
   always @*
   begin
      bit_cnt_next = bit_cnt_reg;
      phase_next   = phase_reg;
      if (sb_start)
      begin
         bit_cnt_next = `BIT_CNT_RESET;
         phase_next   = `PHASE_RESET;
      end
      else if (take)
      begin
         bit_cnt_next = bit_cnt_reg + `BIT_STEP;
         phase_next   = phase_reg + `PHASE_STEP;
      end
   end

   // ************************************************************
   // Sub-block fill state.
   // ************************************************************
   // A bad slot count stops the block at once, even part way through a slot, and
   // parks the machine until the configuration is fixed and a new sub-block starts.
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_OPEN:
         begin
            if (!cfg_ok)
               state_next = ST_BAD;
            else if (last_take)
               state_next = ST_FULL;
         end
         ST_FULL:
         begin
            if (!cfg_ok)
               state_next = ST_BAD;
            else if (sb_start)
               state_next = ST_OPEN;
         end
         ST_BAD:
         begin
            if (cfg_ok && sb_start)
               state_next = ST_OPEN;
         end
         default:
            state_next = ST_OPEN;
      endcase
   end

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         state_reg <= `STATE_RESET;
      else
         state_reg <= state_next;
   end

   // ************************************************************
   // Position registers.
   // ************************************************************
   // slot one at bit zero.
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         bit_cnt_reg <= `BIT_CNT_RESET;
         phase_reg   <= `PHASE_RESET;
      end
      else
      begin
         bit_cnt_reg <= bit_cnt_next;
         phase_reg   <= phase_next;
      end
   end

   // ************************************************************
   // Output bit.
   // ************************************************************
   // flag bad slot count.
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         config_error <= `TX_RESET;
      else
         config_error <= !cfg_ok;
   end

   // Missing user data is sent as the idle fill, so the line timing never slips.
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_bit       <= `TX_RESET;
         tx_bit_valid <= `TX_RESET;
      end
      else
      begin
         tx_bit_valid <= take;
         if (byte_load)
            tx_bit <= user_byte_valid ? user_byte[0] : `FILL_BIT;
         else if (byte_shift)
            tx_bit <= lsb;
         else if (bit_take)
            tx_bit <= user_bit_valid ? user_bit : `FILL_BIT;
      end
   end
endmodule // payload_mapper

// ### verilog/payload_mapper_regs.vh
// Behaviour
// - Transparent mode: fill sub-block with configured bits.
// - Transparent mode: bits keep arrival order.
// - No framing inserted or interpreted.
// - Byte mode: sub-block is 8-bit slots.
// - Byte mode: bytes sent LSB first, next slot.
// - Slot one starts at first bit position.
// - Byte mode length eight times slots, 3..35.
`ifndef PAYLOAD_MAPPER_REGS_VH
`define PAYLOAD_MAPPER_REGS_VH
`define MODE_TRANSPARENT 1'b0
`define MODE_BYTE        1'b1
`define SLOTS_MIN        6'h03
`define SLOTS_MAX_EXCL   6'h24
`define BITS_W           9
`define SLOTS_W          6
`define BIT_CNT_RESET    9'h000
`define BIT_STEP         9'h001
`define PHASE_RESET      3'h0
`define PHASE_STEP       3'h1
`define STATE_RESET      2'h0
`define TX_RESET         1'h0
`define FILL_BIT         1'h1
`define FILL_REST        8'h7F
`define SHIFT_RESET      8'h00
`endif

// ### verilog/bit_shift_reg.v
`timescale 1ns/10ps
`include "payload_mapper_regs.vh"

// ************************************************************
// Byte holding register, shifted out LSB first.
// ************************************************************
module bit_shift_reg
(
   mclk,
   rstn,
   load,
   load_data,
   shift,
   lsb
);
   input  wire       mclk;
   input  wire       rstn;
   input  wire       load;
   input  wire [7:0] load_data;
   input  wire       shift;
   output wire       lsb;

   reg [7:0] data_reg;

   assign lsb = data_reg[0];

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         data_reg <= `SHIFT_RESET;
      else if (load)
         data_reg <= load_data;
      else if (shift)
         data_reg <= {1'b0, data_reg[7:1]};
   end
endmodule // bit_shift_reg

// ### tb/payload_mapper_monitor.sv
`timescale 1ns/10ps
`include "payload_mapper_regs.vh"
// ****
// Port checker.
// ****
module payload_mapper_monitor(
   input wire mclk, rstn, byte_mode, sb_start, bit_req, user_bit, user_bit_valid, user_bit_ready,
   input wire [8:0] payload_bits, input wire [5:0] slot_count, input wire [7:0] user_byte,
   input wire user_byte_valid, user_byte_ready, tx_bit, tx_bit_valid, config_error);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire [8:0] len = byte_mode ? {slot_count, 3'h0} : payload_bits;
   wire       bad_cfg = byte_mode && (slot_count < 6'h03 || slot_count > 6'h23);
   reg  [8:0] pos_reg;
   always @(posedge mclk or negedge rstn)
      if (!rstn) pos_reg <= 9'h000;
      else if (sb_start) pos_reg <= 9'h000;
      else if (bit_req && pos_reg < len) pos_reg <= pos_reg + 9'h001;
   AST_VALID_CAUSE: assert property (tx_bit_valid |-> $past(bit_req) && !$past(sb_start))
      else $error("valid without request");
   AST_FILL: assert property (bit_req && !sb_start && pos_reg < len && !config_error |=> tx_bit_valid)
      else $error("position not filled");
   AST_OVER: assert property (bit_req && pos_reg >= len |=> !tx_bit_valid)
      else $error("bit beyond block");
   AST_ORDER: assert property (!byte_mode && user_bit_ready && user_bit_valid |=> tx_bit == $past(user_bit))
      else $error("bit order");
   AST_BIT_FILL: assert property (!byte_mode && user_bit_ready && !user_bit_valid |=> tx_bit)
      else $error("missing bit not filled");
   AST_LSB: assert property (byte_mode && user_byte_ready && user_byte_valid |=> tx_bit == $past(user_byte[0]))
      else $error("byte not lsb first");
   AST_BYTE_FILL: assert property (byte_mode && user_byte_ready && !user_byte_valid |=> tx_bit)
      else $error("missing byte not filled");
   AST_SLOT: assert property (user_byte_ready |-> byte_mode && bit_req && !sb_start && pos_reg[2:0] == 3'h0)
      else $error("byte off slot");
   AST_SB_DROP: assert property (sb_start |=> !tx_bit_valid)
      else $error("request at block start");
   AST_START_NO_TAKE: assert property (sb_start |-> !user_bit_ready && !user_byte_ready)
      else $error("data taken at block start");
   AST_CFG: assert property (config_error |-> $past(bad_cfg))
      else $error("bad config flag");
   AST_CFG_SET: assert property (bad_cfg |=> config_error)
      else $error("bad config not flagged");
endmodule // payload_mapper_monitor
bind payload_mapper payload_mapper_monitor u_mon(.*);

// ### tb/framer_model.sv
`timescale 1ns/10ps
// ****
// Framer and user source.
// ****
module framer_model(
   input wire logic mclk, go, starve, user_bit_ready, user_byte_ready,
   input wire logic [8:0] reqs, input wire logic [31:0] data,
   output logic sb_start, bit_req, user_bit, user_bit_valid, user_byte_valid, output logic [7:0] user_byte);
   logic [31:0] d;
   logic [9:0]  left;
   assign user_bit = d[0];
   assign user_byte = d[7:0];
   assign user_bit_valid = !starve;
   assign user_byte_valid = !starve;
   initial {sb_start, bit_req, left, d} = '0;
   always @(posedge mclk)
   begin
      d <= go ? data : user_byte_ready && user_byte_valid ? d >> 8 : user_bit_ready && user_bit_valid ? d >> 1 : d;
      left <= go ? {1'b0, reqs} + 10'h001 : left - {9'h000, left != 10'h000};
      // block start, with a request that must be dropped
      sb_start <= #2 go;
      bit_req <= #2 go || left > 10'h001;
   end
endmodule // framer_model

// ### tb/payload_mapper_bench.sv
`timescale 1ns/10ps
module payload_mapper_bench;
   reg mclk = 0, rstn = 0, byte_mode = 0, go = 0, starve = 0;
   reg [8:0] payload_bits = 9'h00A, reqs = 9'h000;
   reg [5:0] slot_count = 6'h03;
   reg [31:0] data = 32'h0, rx = 32'h0;
   wire sb_start, bit_req, user_bit, user_bit_valid, user_bit_ready, user_byte_valid, user_byte_ready;
   wire tx_bit, tx_bit_valid, config_error;
   wire [7:0] user_byte;
   integer fails = 0, compares = 0, cnt = 0, cyc = 0;
   payload_mapper u_dut(.*);
   framer_model u_far(.*);
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      if (go)
      begin
         rx  <= 32'h0;
         cnt <= 0;
      end
      else if (tx_bit_valid)
      begin
         rx  <= {tx_bit, rx[31:1]};
         cnt <= cnt + 1;
      end
      cyc <= cyc + 1;
      if (cyc > 2000) begin fails = fails + 1; test_done; end
   end
   task check(input [31:0] seen, input [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin fails = fails + 1; $display("wrong value at %0t: %h expected %h", $time, seen, exp); end
   endtask
   task frame(input m, input [8:0] pb, input [5:0] sc, input [8:0] n, input [31:0] dat);
      {byte_mode, payload_bits, slot_count, reqs, data} = {m, pb, sc, n, dat};
      repeat (3) @(posedge mclk);
      #2 go = 1;
      @(posedge mclk) #2 go = 0;
      repeat (n + 4) @(posedge mclk);
      #2;
   endtask
   task t_clear;
      frame(1'b0, 9'h00A, 6'h03, 9'h00C, 32'h2C9);
      check(cnt, 32'hA);
      check(rx >> 22, 32'h2C9);
      $display("clear channel test done");
   endtask
   task t_byte;
      frame(1'b1, 9'h00A, 6'h03, 9'h01A, 32'hA53C96);
      check(cnt, 32'h18);
      check(rx >> 8, 32'hA53C96);
      $display("byte test done");
   endtask
   task t_bad;
      frame(1'b1, 9'h00A, 6'h02, 9'h010, 32'h5A);
      check(config_error, 32'h1);
      check(cnt, 32'h0);
      $display("bad slot test done");
   endtask
   task t_limits;
      frame(1'b1, 9'h00A, 6'h23, 9'h11A, 32'h0);
      check(cnt, 32'h118);
      check(config_error, 32'h0);
      frame(1'b1, 9'h00A, 6'h24, 9'h010, 32'h5A);
      check(config_error, 32'h1);
      check(cnt, 32'h0);
      $display("slot limit test done");
   endtask
   task t_starve;
      starve = 1;
      frame(1'b0, 9'h008, 6'h03, 9'h008, 32'h0);
      check(cnt, 32'h8);
      check(rx >> 24, 32'hFF);
      frame(1'b1, 9'h008, 6'h03, 9'h018, 32'h0);
      check(rx >> 8, 32'hFFFFFF);
      starve = 0;
      $display("idle fill test done");
   endtask
   task test_done;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge mclk);
      #2 rstn = 1;
      t_clear;
      t_byte;
      t_bad;
      t_limits;
      t_starve;
      test_done;
   end
endmodule // payload_mapper_bench
